/* include/can_gcs_pkg.sv */
// Package: register map, field positions, reset values and timing for global control/status
package can_gcs_pkg;
   // Byte addresses of the AXI4-Lite register words
   localparam logic [7:0] CTRL_OFFSET = 8'h00;
   localparam logic [7:0] STATUS_OFFSET = 8'haa;
   localparam logic [7:0] STATUS_ADDR = 8'ha8;
   localparam logic [7:0] IRQ_STATUS_ADDR = 8'h10;
   localparam logic [7:0] IRQ_MASK_ADDR = 8'h14;
   localparam logic [7:0] ERR_ADDR = 8'h18;
   // Control register fields
   localparam int CTRL_SOFT_GLOBAL_RESET_BIT = 0;
   localparam int CTRL_RUN_BIT = 1;
   localparam int CTRL_TEST_BIT = 2;
   localparam int CTRL_LISTEN_BIT = 3;
   localparam logic [7:0] CTRL_WRITE_MASK = 8'h0e;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   // Status register fields
   localparam int STA_ERROR_PASSIVE_STATE_BIT = 0;
   localparam int STA_BUS_OFF_STATE_BIT = 1;
   localparam int STA_RUN_BIT = 2;
   localparam int STA_RX_BIT = 3;
   localparam int STA_TX_BIT = 4;
   localparam int STA_OVL_BIT = 6;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   // Interrupt event bits
   localparam int IRQ_RUN_UP_BIT = 0;
   localparam int IRQ_RUN_DOWN_BIT = 1;
   localparam int IRQ_BUSOFF_BIT = 2;
   localparam int IRQ_ERROR_PASSIVE_STATE_BIT = 3;
   localparam int IRQ_WIDTH = 4;
   localparam logic [3:0] IRQ_RESET = 4'h0;
   // Start-up time of the protocol engine after enable
   localparam int START_PERIODS = 2;
   localparam logic [1:0] START_CYCLES = 2'(START_PERIODS);
   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // Run state machine
   typedef enum logic [3:0] {
      ST_STANDBY = 4'b0001,
      ST_STARTING = 4'b0010,
      ST_RUNNING = 4'b0100,
      ST_DRAINING = 4'b1000
   } run_state_t;
endpackage : can_gcs_pkg

/* logic/can_run_control.sv */
// Run/standby sequencer: start-up delay, drain on disable, clock gate
`timescale 1ns/100ps
module can_run_control
   import can_gcs_pkg::*;
(
   input wire logic core_clk,
   input wire logic ctlReset_n,
   input wire logic runEnable,
   input wire logic frameActive,
   output logic protoRunning,
   output logic canClkEnable
);
   import can_gcs_pkg::*;

   run_state_t state_r, state_nxt;
   logic [1:0] startCnt_r, startCnt_nxt;

   // Next state: standby -> starting -> running -> draining -> standby
   always_comb begin
      state_nxt = state_r;
      startCnt_nxt = startCnt_r;
      case (state_r)
         ST_STANDBY: begin
            startCnt_nxt = 2'h0;
            if (runEnable) begin
               state_nxt = ST_STARTING;
            end
         end
         ST_STARTING: begin
            startCnt_nxt = startCnt_r + 2'h1;
            if (!runEnable) begin
               state_nxt = ST_STANDBY;
            end else if (startCnt_r == START_CYCLES - 2'h1) begin
               state_nxt = ST_RUNNING;
            end
         end
         ST_RUNNING: begin
            if (!runEnable) begin
               state_nxt = ST_DRAINING;
            end
         end
         ST_DRAINING: begin
            // Ongoing frame is completed before freezing
            if (!frameActive) begin
               state_nxt = ST_STANDBY;
            end
         end
         default: begin
            state_nxt = ST_STANDBY;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge ctlReset_n) begin
      if (!ctlReset_n) begin
         state_r <= ST_STANDBY;
         startCnt_r <= 2'h0;
         protoRunning <= 1'b0;
         canClkEnable <= 1'b0;
      end else begin
         state_r <= state_nxt;
         startCnt_r <= startCnt_nxt;
         protoRunning <= (state_nxt == ST_RUNNING) || (state_nxt == ST_DRAINING);
         canClkEnable <= (state_nxt != ST_STANDBY);
      end
   end
endmodule : can_run_control

/* logic/can_global_control_status.sv */
// Top: CAN global control/status registers with AXI4-Lite slave and interrupt
//
// Functional notes
// - Run enable set starts controller and clock
// - Run enable clear finishes frame, then freezes
// - Standby drives recessive transmit output
// - Standby: receiver off, controller clock stopped
// - Registers stay accessible while disabled
// - Protocol engine starts two periods after enable
// - Self-clearing soft reset ORed with hardware
// - Reserved status bits indeterminate; never write
// - Overload flag during own overload frame
// - Running flag shows actual enabled state
// - Status fields read only
// - Control register resets to zero
// - Defined status bits reset to zero
`timescale 1ns/100ps
module can_global_control_status
   import can_gcs_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic canRxPin,
   input wire logic engineTxBit,
   input wire logic engineTxBusy,
   input wire logic engineRxBusy,
   input wire logic engineOverload,
   input wire logic engineBusOff,
   input wire logic engineErrPassive,
   input wire logic [7:0] engineTxErrCnt,
   input wire logic [7:0] engineRxErrCnt,
   output logic canTxPin,
   output logic canRxSample,
   output logic protoRun,
   output logic canClkEnable,
   output logic listenOnly,
   output logic testMode,
   output logic ctlReset_n,
   output logic irq
);
   import can_gcs_pkg::*;

   // ==========================================================
   // Reset combining
   // ==========================================================
   logic softReset_r;
   logic ctlRst_r;
   logic protoRunning;
   logic clkEn;

   // Soft reset ORed with hardware reset, registered so it is glitch free
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctlRst_r <= 1'b0;
      end else begin
         ctlRst_r <= !softReset_r;
      end
   end
   assign ctlReset_n = ctlRst_r;

   // ==========================================================
   // Pin and engine input synchronisation
   // ==========================================================
   logic [1:0] rxSync_r;
   logic [5:0] engSync1_r, engSync2_r;
   wire logic [5:0] engRaw = {engineOverload, engineTxBusy, engineRxBusy, 1'b0,
                             engineBusOff, engineErrPassive};

   // Two stages before any logic reads the pin
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rxSync_r <= 2'b11;
         engSync1_r <= 6'h00;
         engSync2_r <= 6'h00;
      end else begin
         rxSync_r <= {rxSync_r[0], canRxPin};
         engSync1_r <= engRaw;
         engSync2_r <= engSync1_r;
      end
   end

   // ==========================================================
   // Control register
   // ==========================================================
   logic [7:0] ctrl_r, ctrl_nxt;
   logic [7:0] status_r, status_nxt;
   logic [IRQ_WIDTH-1:0] irqStat_r, irqStat_nxt, irqMask_r, irqMask_nxt;
   logic wrCtrl, wrMask, wrIrqClr;
   logic [7:0] wrByte;

   // Write picks: only writable bits stored; soft reset bit self clears
   assign ctrl_nxt = wrCtrl ? (wrByte & CTRL_WRITE_MASK) : ctrl_r;

   always_ff @(posedge core_clk or negedge ctlReset_n) begin
      if (!ctlReset_n) begin
         ctrl_r <= CTRL_RESET;
      end else begin
         ctrl_r <= ctrl_nxt;
      end
   end

   // Soft reset pulse lives one cycle only, loaded from the single-cycle control write strobe
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         softReset_r <= 1'b0;
      end else begin
         softReset_r <= wrCtrl && wrByte[CTRL_SOFT_GLOBAL_RESET_BIT];
      end
   end

   // ==========================================================
   // Run sequencer
   // ==========================================================
   can_run_control runCtl (
      .core_clk(core_clk),
      .ctlReset_n(ctlReset_n),
      .runEnable(ctrl_r[CTRL_RUN_BIT]),
      .frameActive(engSync2_r[4] | engSync2_r[3]),
      .protoRunning(protoRunning),
      .canClkEnable(clkEn)
   );

   // ==========================================================
   // Pin drive and mode outputs
   // ==========================================================
   wire logic txDominantAllowed = protoRunning && !ctrl_r[CTRL_LISTEN_BIT];
   wire logic txNext = txDominantAllowed ? engineTxBit : 1'b1;

   always_ff @(posedge core_clk or negedge ctlReset_n) begin
      if (!ctlReset_n) begin
         canTxPin <= 1'b1;
         canRxSample <= 1'b1;
         protoRun <= 1'b0;
         canClkEnable <= 1'b0;
         listenOnly <= 1'b0;
         testMode <= 1'b0;
      end else begin
         canTxPin <= txNext;
         canRxSample <= protoRunning ? rxSync_r[1] : 1'b1;
         protoRun <= protoRunning;
         canClkEnable <= clkEn;
         listenOnly <= ctrl_r[CTRL_LISTEN_BIT];
         testMode <= ctrl_r[CTRL_TEST_BIT];
      end
   end

   // ==========================================================
   // Status register
   // ==========================================================
   // Hardware-owned: software writes never reach it; reserved bits read zero
   always_comb begin
      status_nxt = STATUS_RESET;
      status_nxt[STA_OVL_BIT] = engSync2_r[5];
      status_nxt[STA_TX_BIT] = engSync2_r[4];
      status_nxt[STA_RX_BIT] = engSync2_r[3];
      status_nxt[STA_RUN_BIT] = protoRunning;
      status_nxt[STA_BUS_OFF_STATE_BIT] = engSync2_r[1];
      status_nxt[STA_ERROR_PASSIVE_STATE_BIT] = engSync2_r[0];
   end

   always_ff @(posedge core_clk or negedge ctlReset_n) begin
      if (!ctlReset_n) begin
         status_r <= STATUS_RESET;
      end else begin
         status_r <= status_nxt;
      end
   end

   // ==========================================================
   // Interrupts
   // ==========================================================
   // Events: run up/down edges, bus-off and error-passive entry. Set wins.
   wire logic [IRQ_WIDTH-1:0] irqEvent = {
      status_nxt[STA_ERROR_PASSIVE_STATE_BIT] & ~status_r[STA_ERROR_PASSIVE_STATE_BIT],
      status_nxt[STA_BUS_OFF_STATE_BIT] & ~status_r[STA_BUS_OFF_STATE_BIT],
      ~status_nxt[STA_RUN_BIT] & status_r[STA_RUN_BIT],
      status_nxt[STA_RUN_BIT] & ~status_r[STA_RUN_BIT]};
   wire logic [IRQ_WIDTH-1:0] irqClr = wrIrqClr ? wrByte[IRQ_WIDTH-1:0] : IRQ_RESET;
   assign irqStat_nxt = (irqStat_r & ~irqClr) | irqEvent;
   assign irqMask_nxt = wrMask ? wrByte[IRQ_WIDTH-1:0] : irqMask_r;

   always_ff @(posedge core_clk or negedge ctlReset_n) begin
      if (!ctlReset_n) begin
         irqStat_r <= IRQ_RESET;
         irqMask_r <= IRQ_RESET;
         irq <= 1'b0;
      end else begin
         irqStat_r <= irqStat_nxt;
         irqMask_r <= irqMask_nxt;
         irq <= |(irqStat_nxt & irqMask_nxt);
      end
   end

   // ==========================================================
   // AXI4-Lite slave
   // ==========================================================
   // Word-aligned decode used on both channels
   function automatic logic [7:0] word_addr(input logic [31:0] a);
      word_addr = {a[7:2], 2'b00};
   endfunction : word_addr

   function automatic logic addr_known(input logic [7:0] w);
      addr_known = (w == CTRL_OFFSET) || (w == STATUS_ADDR) || (w == IRQ_STATUS_ADDR)
                   || (w == IRQ_MASK_ADDR) || (w == ERR_ADDR);
   endfunction : addr_known

   logic awHeld_r, wHeld_r;
   logic [7:0] awAddr_r;
   logic [31:0] wData_r;
   logic [3:0] wStrb_r;

   wire logic awTake = s_axi_awvalid && s_axi_awready;
   wire logic wTake = s_axi_wvalid && s_axi_wready;
   wire logic doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;
   wire logic [7:0] wrWord = awAddr_r;
   wire logic laneOk = wStrb_r[0];
   assign wrByte = wData_r[7:0];
   assign wrCtrl = doWrite && laneOk && (wrWord == CTRL_OFFSET);
   assign wrMask = doWrite && laneOk && (wrWord == IRQ_MASK_ADDR);
   assign wrIrqClr = doWrite && laneOk && (wrWord == IRQ_STATUS_ADDR);

   // Write channels captured independently, answered once both are in
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         awHeld_r <= 1'b0;
         wHeld_r <= 1'b0;
         awAddr_r <= 8'h00;
         wData_r <= 32'h0000_0000;
         wStrb_r <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         s_axi_awready <= !awHeld_r && !awTake;
         s_axi_wready <= !wHeld_r && !wTake;
         if (awTake) begin
            awHeld_r <= 1'b1;
            awAddr_r <= word_addr(s_axi_awaddr);
         end
         if (wTake) begin
            wHeld_r <= 1'b1;
            wData_r <= s_axi_wdata;
            wStrb_r <= s_axi_wstrb;
         end
         if (doWrite) begin
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= addr_known(wrWord) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   wire logic arTake = s_axi_arvalid && s_axi_arready;
   wire logic [7:0] rdWord = word_addr(s_axi_araddr);
   wire logic [31:0] rdMux =
      (rdWord == CTRL_OFFSET) ? {24'h000000, ctrl_r} :
      (rdWord == STATUS_ADDR) ? {8'h00, status_r, 16'h0000} :
      (rdWord == IRQ_STATUS_ADDR) ? {28'h0000000, irqStat_r} :
      (rdWord == IRQ_MASK_ADDR) ? {28'h0000000, irqMask_r} :
      (rdWord == ERR_ADDR) ? {16'h0000, engineRxErrCnt, engineTxErrCnt} : 32'h0000_0000;

   // Read answered one cycle after the address is taken
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !arTake;
         if (arTake) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdMux;
            s_axi_rresp <= addr_known(rdWord) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule : can_global_control_status

/* bench/can_gcs_chk.sv */
// Checker: port-level properties of the CAN global control/status block
`timescale 1ns/100ps
module can_gcs_chk (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic canTxPin,
   input wire logic canRxSample,
   input wire logic protoRun,
   input wire logic canClkEnable,
   input wire logic listenOnly,
   input wire logic testMode,
   input wire logic ctlReset_n
);
   // ======================================================
   // Properties, all on the core clock
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   a_standby_tx_recessive: assert property (!canClkEnable && !$past(canClkEnable) |-> canTxPin)
      else $error("transmit pin dominant in standby");
   a_standby_rx_idle: assert property (!canClkEnable && !$past(canClkEnable) |-> canRxSample)
      else $error("receiver active in standby");
   a_listen_no_dominant: assert property (listenOnly && $past(listenOnly) |-> canTxPin)
      else $error("dominant bit driven in listen-only");
   a_start_two_periods: assert property ($rose(canClkEnable) |-> !protoRun [*2] ##1 protoRun)
      else $error("engine start not two periods after enable");
   a_clock_while_run: assert property (protoRun && $past(protoRun) |-> canClkEnable)
      else $error("engine runs with clock gated");
   a_soft_reset_clears: assert property ($fell(ctlReset_n) |=> !protoRun && !testMode && !listenOnly)
      else $error("controller not disabled after reset");
   a_reset_pulse_short: assert property ($fell(ctlReset_n) |=> ctlReset_n)
      else $error("soft reset bit not self-clearing");
   a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before taken");
   a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped before taken");
endmodule : can_gcs_chk

bind can_global_control_status can_gcs_chk i_can_gcs_chk (.core_clk, .reset_n, .s_axi_bvalid,
   .s_axi_bready, .s_axi_bresp, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .canTxPin,
   .canRxSample, .protoRun, .canClkEnable, .listenOnly, .testMode, .ctlReset_n);

/* bench/can_bus_node.sv */
// Partner: one remote CAN node on a wired-AND bus through a transceiver
`timescale 1ns/100ps
module can_bus_node (
   input wire logic core_clk,
   input wire logic txPin,
   input wire logic talk,
   output logic rxPin
);
   logic pattern_r = 1'b1;
   // Remote traffic toggles every cycle; a silent node stays recessive
   always_ff @(posedge core_clk) begin
      pattern_r <= talk ? !pattern_r : 1'b1;
   end
   // Dominant wins on the wire, as through a real transceiver
   assign rxPin = txPin & pattern_r;
endmodule : can_bus_node

/* bench/can_global_control_status_tb.sv */
// Testbench: register access, run/standby sequencing, status and soft reset
`timescale 1ns/100ps
module can_global_control_status_tb;
   import can_gcs_pkg::*;
   typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e; logic [1:0] r;} row_t;
   logic core_clk, reset_n, talk, canRxPin;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
   logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic [3:0] s_axi_wstrb;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic engineTxBit, engineTxBusy, engineRxBusy, engineOverload, engineBusOff, engineErrPassive;
   logic [7:0] engineTxErrCnt, engineRxErrCnt;
   logic canTxPin, canRxSample, protoRun, canClkEnable, listenOnly, testMode, ctlReset_n, irq;
   logic [31:0] d;
   int fail_count = 0;
   int compares = 0;
   // Writes to read-only status leave its defined bits at zero
   row_t rows[6] = '{'{CTRL_OFFSET, 32'h0c, 32'h0c, RESP_OKAY}, '{CTRL_OFFSET, 32'h0, 32'h0, RESP_OKAY},
      '{STATUS_ADDR, 32'h005f0000, 32'h0, RESP_OKAY}, '{IRQ_MASK_ADDR, 32'hf, 32'hf, RESP_OKAY},
      '{IRQ_MASK_ADDR, 32'h0, 32'h0, RESP_OKAY}, '{8'h40, 32'h1, 32'h0, RESP_SLVERR}};

   can_global_control_status i_can_global_control_status (.core_clk, .reset_n, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .canRxPin, .engineTxBit,
      .engineTxBusy, .engineRxBusy, .engineOverload, .engineBusOff, .engineErrPassive,
      .engineTxErrCnt, .engineRxErrCnt, .canTxPin, .canRxSample, .protoRun, .canClkEnable,
      .listenOnly, .testMode, .ctlReset_n, .irq);
   can_bus_node i_can_bus_node (.core_clk, .txPin(canTxPin), .talk, .rxPin(canRxPin));

   // ======================================================
   // Clock and watchdog
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   initial begin
      repeat (20000) @(posedge core_clk);
      fail_count++;
      tally_and_finish();
   end

   // ======================================================
   // Compare and bus tasks
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected at %0t: word %h, wanted %h", $time, g, e);
      end
   endtask : chk
   task automatic chkb(input logic g, input logic e);
      compares++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected at %0t: pin %b, wanted %b", $time, g, e);
      end
   endtask : chkb
   // Valids and ready go up together; each channel dropped at the edge it is taken
   task automatic axw(input logic [7:0] a, input logic [31:0] w, output logic [1:0] r);
      logic done = 1'b0;
      @(posedge core_clk);
      s_axi_awaddr <= {24'h0, a};
      s_axi_wdata <= w;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!done) begin
         @(posedge core_clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
            done = 1'b1;
         end
      end
   endtask : axw
   task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
      logic done = 1'b0;
      @(posedge core_clk);
      s_axi_araddr <= {24'h0, a};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!done) begin
         @(posedge core_clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            v = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
            done = 1'b1;
         end
      end
   endtask : axr
   task automatic tally_and_finish();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : tally_and_finish

   // ======================================================
   // Main sequence
   initial begin
      {reset_n, talk, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
      {s_axi_rready, engineTxBusy, engineRxBusy, engineOverload, engineBusOff} = '0;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr, engineErrPassive} = '0;
      engineTxBit = 1'b1;
      s_axi_wstrb = 4'hf;
      engineTxErrCnt = 8'h3c;
      engineRxErrCnt = 8'hc3;
      repeat (12) @(posedge core_clk);
      reset_n <= 1'b1;
      repeat (2) @(posedge core_clk);
      axr(CTRL_OFFSET, d, rsp);
      chk(d, 32'h0);
      axr(STATUS_ADDR, d, rsp);
      chk(d, 32'h0);
      // Table rows run while the controller is disabled
      foreach (rows[i]) begin
         axw(rows[i].a, rows[i].w, rsp);
         chk(32'(rsp), 32'(rows[i].r));
         axr(rows[i].a, d, rsp);
         chk(d, rows[i].e);
         chk(32'(rsp), 32'(rows[i].r));
      end
      axr(ERR_ADDR, d, rsp);
      chk(d, 32'h0000c33c);
      // Enable: running flag, clock, masked then unmasked interrupt
      axw(CTRL_OFFSET, 32'h2, rsp);
      d = '0;
      for (int i = 0; i < 20 && !d[18]; i++) axr(STATUS_ADDR, d, rsp);
      chkb(d[18], 1'b1);
      chkb(canClkEnable, 1'b1);
      chkb(irq, 1'b0);
      axr(IRQ_STATUS_ADDR, d, rsp);
      chk(d & 32'h1, 32'h1);
      axw(IRQ_MASK_ADDR, 32'h1, rsp);
      repeat (2) @(posedge core_clk);
      chkb(irq, 1'b1);
      axw(IRQ_STATUS_ADDR, 32'h1, rsp);
      repeat (2) @(posedge core_clk);
      chkb(irq, 1'b0);
      // Engine levels reach status; running drives the wire
      {engineTxBusy, engineRxBusy, engineOverload, engineBusOff, engineErrPassive} <= 5'h1f;
      engineTxBit <= 1'b0;
      talk <= 1'b1;
      repeat (6) @(posedge core_clk);
      chkb(canTxPin, 1'b0);
      // Own dominant bit comes back through the wire while running
      chkb(canRxSample, 1'b0);
      axr(STATUS_ADDR, d, rsp);
      chk(d, 32'h005f0000);
      axw(CTRL_OFFSET, 32'ha, rsp);
      repeat (3) @(posedge core_clk);
      chkb(canTxPin, 1'b1);
      chkb(listenOnly, 1'b1);
      // Disable mid-frame: keeps running until the engine goes idle
      axw(CTRL_OFFSET, 32'h0, rsp);
      repeat (10) @(posedge core_clk);
      chkb(protoRun, 1'b1);
      {engineTxBusy, engineRxBusy} <= 2'b00;
      repeat (10) @(posedge core_clk);
      chkb(protoRun, 1'b0);
      chkb(canClkEnable, 1'b0);
      for (int i = 0; i < 4; i++) begin
         @(posedge core_clk);
         chkb(canRxSample, 1'b1);
         chkb(canTxPin, 1'b1);
      end
      axr(STATUS_ADDR, d, rsp);
      chk(d, 32'h00430000);
      // Soft reset from the running state with test and listen set
      axw(CTRL_OFFSET, 32'he, rsp);
      repeat (8) @(posedge core_clk);
      chkb(protoRun, 1'b1);
      chkb(testMode, 1'b1);
      // Run, test and listen written with the reset bit: only the reset may clear them
      axw(CTRL_OFFSET, 32'hf, rsp);
      axr(CTRL_OFFSET, d, rsp);
      chk(d, 32'h0);
      chkb(protoRun, 1'b0);
      chkb(testMode, 1'b0);
      chkb(listenOnly, 1'b0);
      // Hardware reset in mid-run: outputs back to idle, bus usable again
      axw(CTRL_OFFSET, 32'h2, rsp);
      repeat (8) @(posedge core_clk);
      chkb(canTxPin, 1'b0);
      reset_n <= 1'b0;
      repeat (3) @(posedge core_clk);
      chkb(canTxPin, 1'b1);
      chkb(ctlReset_n, 1'b0);
      reset_n <= 1'b1;
      repeat (2) @(posedge core_clk);
      chkb(protoRun, 1'b0);
      chkb(canClkEnable, 1'b0);
      axr(CTRL_OFFSET, d, rsp);
      chk(d, 32'h0);
      tally_and_finish();
   end
endmodule : can_global_control_status_tb
